// ===== rsir_pkg.sv
/*
  Package for the reader status and interrupt register bank.
  Holds register offsets, field positions, reset values and the
  transceiver state encoding. Assumes nothing of its surroundings.
*/
package rsir_pkg;

  // Register offsets, word addresses on the 32-bit slave bus.
  localparam logic [7:0] ADDR_MODEM_STATUS = 8'h03;
  localparam logic [7:0] ADDR_FIFO_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_AUX_STATUS   = 8'h05;
  localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'h06;
  localparam logic [7:0] ADDR_IRQ_REQUEST  = 8'h07;
  localparam logic [7:0] ADDR_CONTROL      = 8'h09;
  localparam logic [7:0] ADDR_ERROR        = 8'h0A;
  localparam logic [7:0] ADDR_THRESHOLD    = 8'h0B;

  // Reset values.
  localparam logic [7:0] RST_AUX_STATUS = 8'h60;
  localparam logic [7:0] RST_ERROR      = 8'h40;
  localparam logic [5:0] RST_THRESHOLD  = 6'h08;

  // Queue capacity in bytes.
  localparam logic [6:0] FIFO_CAPACITY = 7'h40;

  // Shared bit positions.
  localparam int BIT_SET_OR_CLEAR = 7;
  localparam int BIT_IRQ_SUMMARY  = 3;
  localparam int BIT_ERR_SUMMARY  = 2;

  // Request and enable bit positions.
  localparam int IRQ_TIMER = 5;
  localparam int IRQ_SEND  = 4;
  localparam int IRQ_RECV  = 3;
  localparam int IRQ_HALT  = 2;
  localparam int IRQ_NFULL = 1;
  localparam int IRQ_NEMPT = 0;

  // Control bit positions.
  localparam int CTL_STANDBY = 5;
  localparam int CTL_SLEEP   = 4;
  localparam int CTL_CIPHER  = 3;
  localparam int CTL_THALT   = 2;
  localparam int CTL_TGO     = 1;
  localparam int CTL_QCLEAR  = 0;

  // Error bit positions.
  localparam int ERR_KEY    = 6;
  localparam int ERR_RIGHTS = 5;
  localparam int ERR_OVFL   = 4;
  localparam int ERR_CSUM   = 3;
  localparam int ERR_FRAME  = 2;
  localparam int ERR_PARITY = 1;
  localparam int ERR_COLL   = 0;

  // Transceiver state codes.
  localparam logic [2:0] TS_IDLE      = 3'h0;
  localparam logic [2:0] TS_SEND_SOF  = 3'h1;
  localparam logic [2:0] TS_SEND_DATA = 3'h2;
  localparam logic [2:0] TS_SEND_EOF  = 3'h3;
  localparam logic [2:0] TS_RX_ENTRY  = 3'h4;
  localparam logic [2:0] TS_RX_WAIT   = 3'h5;
  localparam logic [2:0] TS_RX_LISTEN = 3'h6;
  localparam logic [2:0] TS_RX_DATA   = 3'h7;

  // Phases reported by the transmitter and receiver engines.
  typedef enum logic [2:0] {
    PH_IDLE, PH_SEND_SOF, PH_SEND_DATA, PH_SEND_EOF,
    PH_RX_ENTRY_A, PH_RX_ENTRY_B, PH_RX_WAIT, PH_RX_LISTEN
  } rsir_phase_t;

endpackage : rsir_pkg

// ===== rsir_regs.sv
/*
  Command and status register bank of the contactless reader core.
  Assumes an Avalon-MM master with waitrequest, and engine logic that
  reports phases, events and strobes synchronous to clk.
*/
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ns

// Overview of operation
// - Transceiver state reads 1, 2, 3 while sending start, payload, end.
// - Reads 4 in receiver entry steps, 5 waiting, 6 listening, 7 receiving.
// - Reads 0 when neither transmitter nor receiver is busy.
// - Status bit 3 is set when any enabled request flag is set.
// - Status bit 2 is set when any error flag is set.
// - Near-full bit is set when 64 minus count is at most threshold.
// - Near-empty bit is set when count is at most threshold.
// - Byte count rises on a lone queue write below 64 and falls on a lone read above 0.
// - Aux bit 7 shows the timer running.
// - Aux bits 6 and 5 show memory programming and checksum finished.
// - Three-bit field gives valid bits of last byte, zero meaning all.
// - Bit 7 of enable and request writes selects set or clear of marks.
// - Enable bits 5 to 0 pass the matching requests to the pin.
// - Timer flag sets when the timer counts down to zero.
// - Send flag sets when sending, programming or checksum work ends.
// - Halt flag sets on termination or unknown command, not host idle.
// - Alert flags latch events and clear only through masked clear write.
// - Control bit 5 is standby, bit 4 deep sleep with clock stopped.
// - Cipher bit set only by finished second authentication step.
// - Control bits 2, 1, 0 are timer halt, go and queue clear strobes.
// - Key and rights errors set on fault, clear when their command starts.
// - Overflow error sets on a write into a full queue.
// - Checksum and frame errors set on fault, clear in receive wait.
// - Parity and collision errors set on fault, clear in receive wait.
module rsir_regs (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM slave.
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Engine phase and status.
  input  wire rsir_pkg::rsir_phase_t engine_phase,
  input  wire logic        receiving,
  input  wire logic        timer_active,
  input  wire logic        nvm_program_done,
  input  wire logic        checksum_done,
  input  wire logic [2:0]  final_byte_valid_bits,
  input  wire logic        rx_checksum_enable,
  // Queue traffic.
  input  wire logic        queue_push,
  input  wire logic        queue_pop,
  // Engine events, one-cycle pulses.
  input  wire logic        timer_reached_zero,
  input  wire logic        send_finished,
  input  wire logic        receive_finished,
  input  wire logic        command_halted,
  input  wire logic        auth_step_two_ok,
  input  wire logic        cipher_off,
  input  wire logic        key_load_start,
  input  wire logic        key_format_fault,
  input  wire logic        nvm_cmd_start,
  input  wire logic        nvm_rights_fault,
  input  wire logic        checksum_fault,
  input  wire logic        frame_start_fault,
  input  wire logic        parity_fault,
  input  wire logic        collision_fault,
  // Outputs to the rest of the device.
  output logic             irq,
  output logic             standby,
  output logic             deep_sleep,
  output logic             cipher_active,
  output logic             timer_halt_strobe,
  output logic             timer_go_strobe,
  output logic             queue_clear_strobe,
  output logic      [6:0]  fifo_byte_count,
  output logic      [5:0]  fifo_alert_threshold
);

  // Complete register state of the block.
  typedef struct packed {
    logic [31:0] rdata;
    logic        ack;
    logic [5:0]  en;
    logic [5:0]  req;
    logic        stby;
    logic        sleep;
    logic        cipher;
    logic        thalt;
    logic        tgo;
    logic        qclr;
    logic [6:0]  count;
    logic [6:0]  err;
    logic [5:0]  thresh;
  } rsir_state_t;

  rsir_state_t st;
  rsir_state_t next_st;

  logic [2:0] ts;
  logic       near_full;
  logic       near_empty;
  logic       irq_any;
  logic       err_any;
  logic       wr_hit;
  logic       rd_hit;
  logic [7:0] wb;
  logic [6:0] push_room;

  // Transceiver state code from the engine phase.
  always_comb begin
    case (engine_phase)
      rsir_pkg::PH_IDLE:       ts = receiving ? rsir_pkg::TS_RX_DATA
                                              : rsir_pkg::TS_IDLE;
      rsir_pkg::PH_SEND_SOF:   ts = rsir_pkg::TS_SEND_SOF;
      rsir_pkg::PH_SEND_DATA:  ts = rsir_pkg::TS_SEND_DATA;
      rsir_pkg::PH_SEND_EOF:   ts = rsir_pkg::TS_SEND_EOF;
      rsir_pkg::PH_RX_ENTRY_A: ts = rsir_pkg::TS_RX_ENTRY;
      rsir_pkg::PH_RX_ENTRY_B: ts = rsir_pkg::TS_RX_ENTRY;
      rsir_pkg::PH_RX_WAIT:    ts = rsir_pkg::TS_RX_WAIT;
      rsir_pkg::PH_RX_LISTEN:  ts = receiving ? rsir_pkg::TS_RX_DATA
                                              : rsir_pkg::TS_RX_LISTEN;
      default:                 ts = rsir_pkg::TS_IDLE;
    endcase
  end

  // Summary and alert levels seen in the status register.
  assign near_full  = (7'(rsir_pkg::FIFO_CAPACITY - st.count)
                       <= {1'b0, st.thresh});
  assign near_empty = (st.count <= {1'b0, st.thresh});
  assign irq_any    = |(st.req & st.en);
  assign err_any    = |st.err;
  assign push_room  = rsir_pkg::FIFO_CAPACITY;

  // Bus decode: one cycle of wait, then the answer on the second edge.
  assign wr_hit = write && !st.ack && byteenable[0];
  assign rd_hit = read && !st.ack;
  assign wb     = writedata[7:0];
  assign waitrequest = (read || write) && !st.ack;

  // Next state of every register.
  always_comb begin
    next_st       = st;
    next_st.ack   = (read || write) && !st.ack;
    next_st.thalt = 1'b0;
    next_st.tgo   = 1'b0;
    next_st.qclr  = 1'b0;

    // Read data captured while the request waits.
    if (rd_hit) begin
      case (address)
        rsir_pkg::ADDR_MODEM_STATUS: next_st.rdata = {24'h000000, 1'b0, ts,
          irq_any, err_any, near_full, near_empty};
        rsir_pkg::ADDR_FIFO_COUNT: next_st.rdata = {25'h0, st.count};
        rsir_pkg::ADDR_AUX_STATUS: next_st.rdata = {24'h000000,
          timer_active, nvm_program_done, checksum_done, 2'b00,
          final_byte_valid_bits};
        rsir_pkg::ADDR_IRQ_ENABLE:  next_st.rdata = {26'h0, st.en};
        rsir_pkg::ADDR_IRQ_REQUEST: next_st.rdata = {26'h0, st.req};
        rsir_pkg::ADDR_CONTROL: next_st.rdata = {26'h0, st.stby,
          st.sleep, st.cipher, 3'b000};
        rsir_pkg::ADDR_ERROR:     next_st.rdata = {25'h0, st.err};
        rsir_pkg::ADDR_THRESHOLD: next_st.rdata = {26'h0, st.thresh};
        default:                  next_st.rdata = 32'h00000000;
      endcase
    end

    // Byte count follows queue traffic; a push when full is refused.
    if (queue_push && !queue_pop && st.count != push_room)
      next_st.count = 7'(st.count + 7'h01);
    else if (queue_pop && !queue_push && st.count != 7'h00)
      next_st.count = 7'(st.count - 7'h01);

    // Automatic clears come before the error events so that a fault wins.
    if (engine_phase == rsir_pkg::PH_RX_WAIT) begin
      next_st.err[rsir_pkg::ERR_CSUM]   = 1'b0;
      next_st.err[rsir_pkg::ERR_FRAME]  = 1'b0;
      next_st.err[rsir_pkg::ERR_PARITY] = 1'b0;
      next_st.err[rsir_pkg::ERR_COLL]   = 1'b0;
    end
    if (key_load_start)
      next_st.err[rsir_pkg::ERR_KEY] = 1'b0;
    if (nvm_cmd_start)
      next_st.err[rsir_pkg::ERR_RIGHTS] = 1'b0;

    // Software writes.
    if (wr_hit) begin
      case (address)
        rsir_pkg::ADDR_IRQ_ENABLE:
          if (wb[rsir_pkg::BIT_SET_OR_CLEAR])
            next_st.en = st.en | wb[5:0];
          else
            next_st.en = st.en & ~wb[5:0];
        rsir_pkg::ADDR_IRQ_REQUEST:
          if (wb[rsir_pkg::BIT_SET_OR_CLEAR])
            next_st.req = st.req | wb[5:0];
          else
            next_st.req = st.req & ~wb[5:0];
        rsir_pkg::ADDR_CONTROL: begin
          next_st.stby  = wb[rsir_pkg::CTL_STANDBY];
          next_st.sleep = wb[rsir_pkg::CTL_SLEEP];
          if (!wb[rsir_pkg::CTL_CIPHER])
            next_st.cipher = 1'b0;
          next_st.thalt = wb[rsir_pkg::CTL_THALT];
          next_st.tgo   = wb[rsir_pkg::CTL_TGO];
          next_st.qclr  = wb[rsir_pkg::CTL_QCLEAR];
          if (wb[rsir_pkg::CTL_QCLEAR]) begin
            next_st.count = 7'h00;
            next_st.err[rsir_pkg::ERR_OVFL] = 1'b0;
          end
        end
        rsir_pkg::ADDR_THRESHOLD: next_st.thresh = wb[5:0];
        default: ;
      endcase
    end

    // Cipher follows the engine; only the second authentication sets it.
    if (cipher_off)
      next_st.cipher = 1'b0;
    if (auth_step_two_ok)
      next_st.cipher = 1'b1;

    // Hardware events set flags after any clear, so a set wins.
    if (timer_reached_zero)
      next_st.req[rsir_pkg::IRQ_TIMER] = 1'b1;
    if (send_finished)
      next_st.req[rsir_pkg::IRQ_SEND] = 1'b1;
    if (receive_finished)
      next_st.req[rsir_pkg::IRQ_RECV] = 1'b1;
    if (command_halted)
      next_st.req[rsir_pkg::IRQ_HALT] = 1'b1;
    if (near_full)
      next_st.req[rsir_pkg::IRQ_NFULL] = 1'b1;
    if (near_empty)
      next_st.req[rsir_pkg::IRQ_NEMPT] = 1'b1;
    if (key_format_fault)
      next_st.err[rsir_pkg::ERR_KEY] = 1'b1;
    if (nvm_rights_fault)
      next_st.err[rsir_pkg::ERR_RIGHTS] = 1'b1;
    if (checksum_fault && rx_checksum_enable)
      next_st.err[rsir_pkg::ERR_CSUM] = 1'b1;
    if (frame_start_fault)
      next_st.err[rsir_pkg::ERR_FRAME] = 1'b1;
    if (parity_fault)
      next_st.err[rsir_pkg::ERR_PARITY] = 1'b1;
    if (collision_fault)
      next_st.err[rsir_pkg::ERR_COLL] = 1'b1;
    // Overflow is set after the flush clear, so a push into a full queue wins.
    if (queue_push && !queue_pop && st.count == push_room)
      next_st.err[rsir_pkg::ERR_OVFL] = 1'b1;
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st        <= '0;
      st.err    <= rsir_pkg::RST_ERROR[6:0];
      st.thresh <= rsir_pkg::RST_THRESHOLD;
    end else begin
      st <= next_st;
    end
  end

  // Outputs from the registered state.
  assign readdata             = st.rdata;
  assign irq                  = irq_any;
  assign standby              = st.stby;
  assign deep_sleep           = st.sleep;
  assign cipher_active        = st.cipher;
  assign timer_halt_strobe    = st.thalt;
  assign timer_go_strobe      = st.tgo;
  assign queue_clear_strobe   = st.qclr;
  assign fifo_byte_count      = st.count;
  assign fifo_alert_threshold = st.thresh;

endmodule : rsir_regs

// ===== rsir_regs_sva.sv
/*
  Port assertions for the reader status and interrupt register bank.
  Assumes a bind onto rsir_regs, one clock, byteenable held all ones.
*/
`timescale 1ns/1ns
module rsir_regs_sva (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        reset,
  // Bus.
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Engine side and outputs.
  input wire rsir_pkg::rsir_phase_t engine_phase,
  input wire logic        receiving,
  input wire logic        queue_push,
  input wire logic        queue_pop,
  input wire logic        auth_step_two_ok,
  input wire logic        standby,
  input wire logic        cipher_active,
  input wire logic        timer_halt_strobe,
  input wire logic        timer_go_strobe,
  input wire logic        queue_clear_strobe,
  input wire logic [6:0]  fifo_byte_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Taken control writes, and cycles that no control write disturbs.
  logic ctl_wr;
  logic quiet;
  logic st_rd;
  assign ctl_wr = write && waitrequest && address == rsir_pkg::ADDR_CONTROL;
  assign quiet  = !(write && address == rsir_pkg::ADDR_CONTROL);
  assign st_rd = read && waitrequest && address == rsir_pkg::ADDR_MODEM_STATUS;
  count_up_a: assert property (
    queue_push && !queue_pop && quiet && fifo_byte_count < 7'h40
    |=> fifo_byte_count == $past(fifo_byte_count) + 7'h01)
    else $error("count did not rise on push");
  count_down_a: assert property (
    queue_pop && !queue_push && quiet && fifo_byte_count != 7'h00
    |=> fifo_byte_count == $past(fifo_byte_count) - 7'h01)
    else $error("count did not fall on pop");
  full_hold_a: assert property (
    queue_push && !queue_pop && quiet && fifo_byte_count == 7'h40
    |=> $stable(fifo_byte_count))
    else $error("count moved past capacity");
  flush_pulse_a: assert property (ctl_wr && writedata[0] |=>
    queue_clear_strobe && fifo_byte_count == 7'h00 ##1 !queue_clear_strobe)
    else $error("flush strobe or count wrong");
  go_pulse_a: assert property (ctl_wr && writedata[1] |=>
    timer_go_strobe ##1 !timer_go_strobe) else $error("go strobe wrong");
  halt_pulse_a: assert property (ctl_wr && writedata[2] |=>
    timer_halt_strobe ##1 !timer_halt_strobe)
    else $error("halt strobe wrong");
  standby_store_a: assert property (ctl_wr |=>
    standby == $past(writedata[5])) else $error("standby not stored");
  cipher_set_a: assert property (auth_step_two_ok |=>
    cipher_active) else $error("cipher not set");
  cipher_cause_a: assert property ($rose(cipher_active) |->
    $past(auth_step_two_ok)) else $error("cipher set without cause");
  send_state_a: assert property (st_rd && engine_phase inside
    {rsir_pkg::PH_SEND_SOF, rsir_pkg::PH_SEND_DATA, rsir_pkg::PH_SEND_EOF}
    |=> readdata[6:4] == $past(engine_phase)) else $error("send state code");
  idle_state_a: assert property (st_rd && !receiving
    && engine_phase == rsir_pkg::PH_IDLE |=> readdata[6:4] == 3'h0)
    else $error("idle state code");
  // Main scenarios.
  cover property (ctl_wr && writedata[0]);
  cover property (queue_push && fifo_byte_count == 7'h40);
  cover property ($rose(cipher_active));
endmodule : rsir_regs_sva

// ===== rsir_host.sv
/*
  Host processor model that reaches the bank over Avalon-MM.
  Assumes the slave answers through waitrequest on the same clock.
*/
`timescale 1ns/1ns
module rsir_host (
  // Clock.
  input  wire logic        clk,
  // Avalon-MM master.
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic      [7:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  // Completed read, standing for one cycle.
  output logic             rd_valid,
  output logic      [31:0] rd_data
);
  // Idle bus at time zero.
  initial begin
    {address, read, write, writedata, rd_valid, rd_data} = '0;
  end
  // Holds the request until waitrequest is sampled low at a rising edge,
  // takes the read data at that same edge, then releases the bus.
  // A read result stands for the one cycle after completion.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= {24'h000000, d};
    read      <= !wr;
    write     <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd_valid <= !wr;
    rd_data  <= readdata;
    read     <= 1'b0;
    write    <= 1'b0;
    @(posedge clk);
    rd_valid <= 1'b0;
  endtask : xfer
endmodule : rsir_host

// ===== reader_status_irq_regs_tb.sv
/*
  Self-checking bench for the status and interrupt register bank.
  Assumes the host model drives the bus; the bench drives engine inputs.
*/
`timescale 1ns/1ns
module reader_status_irq_regs_tb;
  logic clk = 1'b0;
  logic reset;
  logic [7:0] address;
  logic read, write, waitrequest, irq, standby, deep_sleep, cipher_active;
  logic [31:0] writedata, readdata;
  logic timer_halt_strobe, timer_go_strobe, queue_clear_strobe;
  logic [6:0] fifo_byte_count;
  logic [5:0] fifo_alert_threshold;
  rsir_pkg::rsir_phase_t engine_phase;
  logic receiving, timer_active, nvm_program_done, checksum_done;
  logic rx_checksum_enable, queue_push, queue_pop;
  logic [2:0] final_byte_valid_bits;
  logic [13:0] ev;
  logic [15:0] note_q[$];
  int n_errors = 0;
  int samples_checked = 0;
  logic [15:0] rst_tab [0:6] = '{16'h0400, 16'h0560, 16'h0600, 16'h0701,
                                 16'h0900, 16'h0A40, 16'h0800};
  logic [2:0] st_tab [0:7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h6};
  int cnt_tab [0:3] = '{8, 9, 55, 56};

  always #20 clk = ~clk;

  rsir_regs u_rsir_regs (.clk, .reset, .address, .read, .write, .writedata,
    .byteenable(4'hF), .readdata, .waitrequest, .engine_phase, .receiving,
    .timer_active, .nvm_program_done, .checksum_done, .final_byte_valid_bits,
    .rx_checksum_enable, .queue_push, .queue_pop, .timer_reached_zero(ev[0]),
    .send_finished(ev[1]), .receive_finished(ev[2]), .command_halted(ev[3]),
    .auth_step_two_ok(ev[4]), .cipher_off(ev[5]), .key_load_start(ev[6]),
    .key_format_fault(ev[7]), .nvm_cmd_start(ev[8]), .nvm_rights_fault(ev[9]),
    .checksum_fault(ev[10]), .frame_start_fault(ev[11]),
    .parity_fault(ev[12]), .collision_fault(ev[13]), .irq, .standby,
    .deep_sleep, .cipher_active, .timer_halt_strobe, .timer_go_strobe,
    .queue_clear_strobe, .fifo_byte_count, .fifo_alert_threshold);
  rsir_host u_rsir_host (.clk, .waitrequest, .readdata, .address, .read,
    .write, .writedata, .rd_valid(), .rd_data());

  // Counts one comparison and reports a difference.
  task automatic see(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : see
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    note_q.push_back({a, e});
    u_rsir_host.xfer(1'b0, a, 8'h00);
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_rsir_host.xfer(1'b1, a, d);
  endtask : wr
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask : pulse
  // Holds push or pop high for n cycles, one byte per cycle.
  task automatic move(input bit pop, input int n);
    @(posedge clk);
    if (pop) queue_pop <= 1'b1; else queue_push <= 1'b1;
    repeat (n) @(posedge clk);
    queue_pop  <= 1'b0;
    queue_push <= 1'b0;
  endtask : move
  task automatic tally_and_finish;
    n_errors += note_q.size();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // Compares every completed read with the oldest note.
  always @(posedge clk) begin
    if (u_rsir_host.rd_valid === 1'b1 && note_q.size() > 0) begin
      see($sformatf("reg_%h", note_q[0][15:8]), {24'h0, note_q[0][7:0]},
          u_rsir_host.rd_data);
      void'(note_q.pop_front());
    end
  end

  // Cuts a hang short.
  initial begin
    #(40 * 20000);
    n_errors++;
    tally_and_finish;
  end

  initial begin
    logic [7:0] m, e;
    int n;
    reset = 1'b1;
    ev = '0;
    {receiving, timer_active, rx_checksum_enable, queue_push, queue_pop} = '0;
    {nvm_program_done, checksum_done} = 2'b11;
    final_byte_valid_bits = 3'h0;
    engine_phase = rsir_pkg::PH_IDLE;
    m = 8'($urandom(32'hC1495CA0));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 7; i++) chk(rst_tab[i][15:8], rst_tab[i][7:0]);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      engine_phase <= rsir_pkg::rsir_phase_t'(i);
      chk(8'h03, {1'b0, st_tab[i], 4'h5});
    end
    receiving <= 1'b1;
    chk(8'h03, 8'h75);
    receiving <= 1'b0;
    engine_phase <= rsir_pkg::PH_IDLE;
    $display("test transceiver state done");
    m = 8'($urandom()) & 8'h3F;
    wr(8'h06, 8'h80 | m);
    chk(8'h06, m);
    wr(8'h06, 8'h2A);
    e = m & 8'h15;
    chk(8'h06, e);
    wr(8'h07, 8'hBE);
    chk(8'h07, 8'h3F);
    chk(8'h03, {4'h0, e != 8'h00, 3'h5});
    @(negedge clk);
    see("irq", 32'(e != 8'h00), 32'(irq));
    wr(8'h07, 8'h3E);
    chk(8'h07, 8'h01);
    @(negedge clk);
    see("irq", 32'(e[0]), 32'(irq));
    for (int i = 0; i < 4; i++) begin
      wr(8'h07, 8'h3E);
      pulse(i);
      chk(8'h07, 8'h01 | (8'h20 >> i));
    end
    wr(8'h06, 8'h3F);
    @(negedge clk);
    see("irq", 32'h0, 32'(irq));
    $display("test interrupt marks done");
    wr(8'h07, 8'h3E);
    for (int i = 0; i < 4; i++) begin
      n = cnt_tab[i];
      wr(8'h09, 8'h01);
      move(1'b0, n);
      chk(8'h03, {6'h01, 64 - n <= 8, n <= 8});
      chk(8'h04, 8'(n));
    end
    move(1'b1, 2);
    chk(8'h03, 8'h04);
    chk(8'h07, 8'h03);
    move(1'b0, 11);
    chk(8'h04, 8'h40);
    chk(8'h0A, 8'h50);
    wr(8'h09, 8'h01);
    chk(8'h04, 8'h00);
    chk(8'h0A, 8'h40);
    $display("test queue count done");
    pulse(6);
    chk(8'h0A, 8'h00);
    chk(8'h03, 8'h01);
    pulse(9);
    chk(8'h0A, 8'h20);
    pulse(8);
    pulse(7);
    chk(8'h0A, 8'h40);
    rx_checksum_enable <= 1'b1;
    for (int i = 10; i < 14; i++) pulse(i);
    chk(8'h0A, 8'h4F);
    engine_phase <= rsir_pkg::PH_RX_WAIT;
    chk(8'h0A, 8'h40);
    engine_phase <= rsir_pkg::PH_IDLE;
    $display("test error flags done");
    wr(8'h09, 8'h38);
    chk(8'h09, 8'h30);
    @(negedge clk);
    see("deep_sleep", 32'h1, 32'(deep_sleep));
    wr(8'h09, 8'h06);
    chk(8'h09, 8'h00);
    pulse(4);
    chk(8'h09, 8'h08);
    wr(8'h09, 8'h00);
    chk(8'h09, 8'h00);
    $display("test control done");
    repeat (4) begin
      m = 8'($urandom());
      {timer_active, nvm_program_done, checksum_done} <= m[2:0];
      final_byte_valid_bits <= m[5:3];
      chk(8'h05, {m[2:0], 2'b00, m[5:3]});
    end
    $display("test aux status done");
    // A random threshold moves both alert levels for a count of five.
    m = 8'($urandom()) & 8'h3F;
    wr(8'h0B, m);
    chk(8'h0B, m);
    @(negedge clk);
    see("threshold", 32'(m), 32'(fifo_alert_threshold));
    move(1'b0, 5);
    chk(8'h03, {5'h00, 1'b1, m >= 8'd59, m >= 8'd5});
    $display("test threshold done");
    repeat (3) @(posedge clk);
    tally_and_finish;
  end
endmodule : reader_status_irq_regs_tb

bind rsir_regs rsir_regs_sva u_rsir_regs_sva (.clk, .reset, .address, .read,
  .write, .writedata, .readdata, .waitrequest, .engine_phase, .receiving,
  .queue_push, .queue_pop, .auth_step_two_ok, .standby, .cipher_active,
  .timer_halt_strobe, .timer_go_strobe, .queue_clear_strobe,
  .fifo_byte_count);
